/* File: hw/jlp_regs.svh */
/*
  Register indices, field ranges and reset values of the link
  parameter bank. Assumes byte address = 4 x index on the bus.
*/
`ifndef JLP_REGS_SVH
`define JLP_REGS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define JLP_IDX_DEVICE_ID 12'h450
`define JLP_IDX_LANES 12'h453
`define JLP_IDX_OCTETS 12'h454
`define JLP_IDX_FRAMES 12'h455
`define JLP_IDX_CONV 12'h456
`define JLP_IDX_CTRL_RES 12'h457
`define JLP_IDX_SUBCLASS 12'h458
`define JLP_IDX_VERSION 12'h459
`define JLP_IDX_DENSITY 12'h45A
`define JLP_IDX_RES_ONE 12'h45B
`define JLP_IDX_RES_TWO 12'h45C
`define JLP_IDX_CHECKSUM 12'h45D
`define JLP_IDX_STATUS 12'h45E

// ----------------------------------------
// Field positions
// ----------------------------------------
`define JLP_TOP3 7:5
`define JLP_LOW5 4:0
`define JLP_CTRL_BITS 7:6
`define JLP_TOP_BIT 7
`define JLP_ST_MATCH 0
`define JLP_ST_LOCKED 1
`define JLP_ST_SOFT 2

// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define JLP_RST_SCR 1'b1
`define JLP_RST_FRAMES 5'h1F
`define JLP_FRAMES_16 5'h0F
`define JLP_RST_LANES 5'h07
`define JLP_RST_OCTETS 8'h00
`define JLP_RST_CONV 8'h01
`define JLP_RST_RES 5'h0F
`define JLP_RST_NP 5'h0F
`define JLP_RST_SPF 5'h01
`define JLP_RST_HD 1'b1
`define JLP_ZERO3 3'h0
`define JLP_ZERO8 8'h00
`define JLP_PAD 24'h00_0000

`endif

/* File: hw/jlp_pkg.sv */
/*
  Types shared by the link parameter bank files.
  Assumes jlp_regs.svh supplies the numeric constants.
*/
package jlp_pkg;
  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [13:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } jlp_wb_req_type;

  // Settings handed to the serial receiver core
  typedef struct packed {
    logic descramble_en;
    logic [4:0] frames_per_mf;
    logic [2:0] subclass;
    logic [2:0] version;
    logic [7:0] reserved_one;
    logic [7:0] reserved_two;
    logic [7:0] checksum;
  } jlp_link_cfg_type;

  typedef logic [2:0][7:0] jlp_id_bytes_type;
  typedef logic [12:0][7:0] jlp_cks_bytes_type;
endpackage

/* File: hw/jlp_wb_front.sv */
/*
  Classic Wishbone slave front end: one wait state, registered ack
  and read data. Assumes the master holds its request until ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "jlp_regs.svh"

module jlp_wb_front (
  input wire logic sys_clk,
  input wire logic reset,
  input wire jlp_pkg::jlp_wb_req_type wb_req,
  input wire logic [7:0] rd_data,
  output logic wb_ack,
  output logic [31:0] wb_dat,
  output logic acc,
  output logic acc_we,
  output logic acc_lane0,
  output logic [11:0] acc_idx,
  output logic [7:0] acc_data
);
  import jlp_pkg::*;

  // Access is taken once, in the cycle before ack
  assign acc = wb_req.cyc & wb_req.stb & ~wb_ack;
  assign acc_we = wb_req.we;
  assign acc_lane0 = wb_req.sel[0];
  assign acc_idx = wb_req.adr[13:2];
  assign acc_data = wb_req.dat[7:0];

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      wb_ack <= 1'b0;
    else
      wb_ack <= acc;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      wb_dat <= {`JLP_PAD, `JLP_ZERO8};
    else if (acc & ~wb_req.we)
      wb_dat <= {`JLP_PAD, rd_data};
  end
endmodule // jlp_wb_front

`default_nettype wire

/* File: hw/jlp_cksum.sv */
/*
  Running byte sum of the link parameter bytes, modulo 256,
  compared with the programmed checksum. Inputs are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module jlp_cksum (
  input wire logic sys_clk,
  input wire logic reset,
  input wire jlp_pkg::jlp_cks_bytes_type bytes,
  input wire logic [7:0] expected,
  output logic [7:0] sum,
  output logic match
);
  import jlp_pkg::*;

  function automatic logic [7:0] byte_sum(jlp_cks_bytes_type b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 13; i++)
      s = s + b[i];
    return s;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sum <= 8'h00;
      match <= 1'b0;
    end
    else
    begin
      sum <= byte_sum(bytes);
      match <= (byte_sum(bytes) == expected);
    end
  end
endmodule // jlp_cksum

`default_nettype wire

/* File: hw/jlp_link_param_regs.sv */
/*
  Link parameter register bank for the serial receiver core,
  reached over classic Wishbone, 8-bit data in the low byte.
  Assumes soft_reset_held and link_id_bytes come from the
  neighbouring control bank, synchronous to sys_clk.
*/
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "jlp_regs.svh"

module jlp_link_param_regs #(
  parameter logic [4:0] LANES_M1 = `JLP_RST_LANES,
  parameter logic [7:0] OCTETS_M1 = `JLP_RST_OCTETS,
  parameter logic [7:0] CONV_M1 = `JLP_RST_CONV,
  parameter logic [4:0] RES_M1 = `JLP_RST_RES,
  parameter logic [4:0] NP_M1 = `JLP_RST_NP,
  parameter logic [4:0] SPF_M1 = `JLP_RST_SPF,
  parameter logic HIGH_DENSITY = `JLP_RST_HD
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire jlp_pkg::jlp_wb_req_type wb_req,
  output wire logic wb_ack,
  output wire logic [31:0] wb_dat,
  input wire logic soft_reset_held,
  input wire jlp_pkg::jlp_id_bytes_type link_id_bytes,
  output var jlp_pkg::jlp_link_cfg_type link_cfg,
  output logic locked_write_seen,
  output wire logic checksum_match
);
  import jlp_pkg::*;

  logic acc;
  logic acc_we;
  logic acc_lane0;
  logic [11:0] acc_idx;
  logic [7:0] acc_data;
  logic [7:0] rd_data;
  logic [7:0] cks_sum;
  logic wr;
  logic rd;
  jlp_cks_bytes_type cks_bytes;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic frames_ok(logic [4:0] v);
    return (v == `JLP_FRAMES_16) || (v == `JLP_RST_FRAMES);
  endfunction

  function automatic logic is_locked(logic [11:0] idx);
    return (idx == `JLP_IDX_SUBCLASS) ||
      (idx == `JLP_IDX_VERSION) ||
      (idx == `JLP_IDX_RES_ONE) ||
      (idx == `JLP_IDX_RES_TWO) ||
      (idx == `JLP_IDX_CHECKSUM);
  endfunction

  assign wr = acc & acc_we & acc_lane0;
  assign rd = acc & ~acc_we;

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  jlp_wb_front u_front (
    .sys_clk(sys_clk),
    .reset(reset),
    .wb_req(wb_req),
    .rd_data(rd_data),
    .wb_ack(wb_ack),
    .wb_dat(wb_dat),
    .acc(acc),
    .acc_we(acc_we),
    .acc_lane0(acc_lane0),
    .acc_idx(acc_idx),
    .acc_data(acc_data)
  );

  // ----------------------------------------
  // Writable link settings
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      link_cfg.descramble_en <= `JLP_RST_SCR;
      link_cfg.frames_per_mf <= `JLP_RST_FRAMES;
      link_cfg.subclass <= `JLP_ZERO3;
      link_cfg.version <= `JLP_ZERO3;
      link_cfg.reserved_one <= `JLP_ZERO8;
      link_cfg.reserved_two <= `JLP_ZERO8;
      link_cfg.checksum <= `JLP_ZERO8;
    end
    else if (wr)
    begin
      unique case (acc_idx)
        `JLP_IDX_LANES:
          link_cfg.descramble_en <= acc_data[`JLP_TOP_BIT];
        `JLP_IDX_FRAMES:
          if (frames_ok(acc_data[`JLP_LOW5]))
            link_cfg.frames_per_mf <= acc_data[`JLP_LOW5];
        `JLP_IDX_SUBCLASS:
          link_cfg.subclass <= acc_data[`JLP_TOP3];
        `JLP_IDX_VERSION:
          link_cfg.version <= acc_data[`JLP_TOP3];
        `JLP_IDX_RES_ONE:
          link_cfg.reserved_one <= acc_data;
        `JLP_IDX_RES_TWO:
          link_cfg.reserved_two <= acc_data;
        `JLP_IDX_CHECKSUM:
          link_cfg.checksum <= acc_data;
        default:
          ;
      endcase
    end
  end

  // ----------------------------------------
  // Write outside soft reset
  // ----------------------------------------
  // flag locked writes
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      locked_write_seen <= 1'b0;
    else if (wr && is_locked(acc_idx) && !soft_reset_held)
      locked_write_seen <= 1'b1;
    else if (wr && acc_idx == `JLP_IDX_STATUS &&
      acc_data[`JLP_ST_LOCKED])
      locked_write_seen <= 1'b0;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb
  begin
    rd_data = `JLP_ZERO8;
    unique case (acc_idx)
      `JLP_IDX_LANES:
        rd_data = {link_cfg.descramble_en, 2'b00, LANES_M1};
      `JLP_IDX_OCTETS:
        rd_data = OCTETS_M1;
      `JLP_IDX_FRAMES:
        rd_data = {`JLP_ZERO3, link_cfg.frames_per_mf};
      `JLP_IDX_CONV:
        rd_data = CONV_M1;
      `JLP_IDX_CTRL_RES:
        rd_data = {`JLP_ZERO3, RES_M1};
      `JLP_IDX_SUBCLASS:
        rd_data = {link_cfg.subclass, NP_M1};
      `JLP_IDX_VERSION:
        rd_data = {link_cfg.version, SPF_M1};
      `JLP_IDX_DENSITY:
        rd_data = {HIGH_DENSITY, 7'h00};
      `JLP_IDX_RES_ONE:
        rd_data = link_cfg.reserved_one;
      `JLP_IDX_RES_TWO:
        rd_data = link_cfg.reserved_two;
      `JLP_IDX_CHECKSUM:
        rd_data = link_cfg.checksum;
      `JLP_IDX_STATUS:
        rd_data = {5'h00, soft_reset_held,
          locked_write_seen, checksum_match};
      default:
        rd_data = `JLP_ZERO8;
    endcase
  end

  // ----------------------------------------
  // Checksum compare
  // ----------------------------------------
  always_comb
  begin
    cks_bytes[0] = link_id_bytes[0];
    cks_bytes[1] = link_id_bytes[1];
    cks_bytes[2] = link_id_bytes[2];
    cks_bytes[3] = {link_cfg.descramble_en, 2'b00, LANES_M1};
    cks_bytes[4] = OCTETS_M1;
    cks_bytes[5] = {`JLP_ZERO3, link_cfg.frames_per_mf};
    cks_bytes[6] = CONV_M1;
    cks_bytes[7] = {`JLP_ZERO3, RES_M1};
    cks_bytes[8] = {link_cfg.subclass, NP_M1};
    cks_bytes[9] = {link_cfg.version, SPF_M1};
    cks_bytes[10] = {HIGH_DENSITY, 7'h00};
    cks_bytes[11] = link_cfg.reserved_one;
    cks_bytes[12] = link_cfg.reserved_two;
  end

  jlp_cksum u_cksum (
    .sys_clk(sys_clk),
    .reset(reset),
    .bytes(cks_bytes),
    .expected(link_cfg.checksum),
    .sum(cks_sum),
    .match(checksum_match)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  property p_lanes_ro;
    rd && acc_idx == `JLP_IDX_LANES |=>
      wb_dat[`JLP_LOW5] == `JLP_RST_LANES && wb_dat[6:5] == 2'b00;
  endproperty
  a_lanes_ro: assert property (p_lanes_ro)
    else $error("lane count readback wrong");

  property p_octets_ro;
    rd && acc_idx == `JLP_IDX_OCTETS |=>
      wb_dat[7:0] == `JLP_RST_OCTETS;
  endproperty
  a_octets_ro: assert property (p_octets_ro)
    else $error("octets readback changed");

  property p_conv_ro;
    rd && acc_idx == `JLP_IDX_CONV |=>
      wb_dat[7:0] == `JLP_RST_CONV;
  endproperty
  a_conv_ro: assert property (p_conv_ro)
    else $error("converter readback wrong");

  property p_res_ro;
    rd && acc_idx == `JLP_IDX_CTRL_RES |=>
      wb_dat[7:0] == {`JLP_ZERO3, `JLP_RST_RES};
  endproperty
  a_res_ro: assert property (p_res_ro)
    else $error("resolution readback wrong");

  property p_subclass_wr;
    wr && acc_idx == `JLP_IDX_SUBCLASS |=>
      link_cfg.subclass == $past(acc_data[`JLP_TOP3]) ##1
      $stable(link_cfg.subclass);
  endproperty
  a_subclass_wr: assert property (p_subclass_wr)
    else $error("subclass not stored");

  property p_locked_flag;
    wr && is_locked(acc_idx) && !soft_reset_held |=>
      locked_write_seen;
  endproperty
  a_locked_flag: assert property (p_locked_flag)
    else $error("locked write not flagged");

  property p_np_ro;
    rd && acc_idx == `JLP_IDX_SUBCLASS |=>
      wb_dat[`JLP_LOW5] == `JLP_RST_NP &&
      wb_dat[`JLP_TOP3] == link_cfg.subclass;
  endproperty
  a_np_ro: assert property (p_np_ro)
    else $error("bits per sample wrong");

  property p_version_wr;
    wr && acc_idx == `JLP_IDX_VERSION |=>
      link_cfg.version == $past(acc_data[`JLP_TOP3]);
  endproperty
  a_version_wr: assert property (p_version_wr)
    else $error("version not stored");

  property p_spf_ro;
    rd && acc_idx == `JLP_IDX_VERSION |=>
      wb_dat[`JLP_LOW5] == `JLP_RST_SPF;
  endproperty
  a_spf_ro: assert property (p_spf_ro)
    else $error("samples per frame wrong");

  property p_density;
    rd && acc_idx == `JLP_IDX_DENSITY |=>
      wb_dat[7:0] == {`JLP_RST_HD, 7'h00};
  endproperty
  a_density: assert property (p_density)
    else $error("density readback wrong");

  property p_res_one;
    wr && acc_idx == `JLP_IDX_RES_ONE |=>
      link_cfg.reserved_one == $past(acc_data) ##1
      cks_sum == $past(cks_sum) + link_cfg.reserved_one -
      $past(link_cfg.reserved_one, 2);
  endproperty
  a_res_one: assert property (p_res_one)
    else $error("reserved byte not stored");

  property p_scr_reset;
    $fell(reset) |-> link_cfg.descramble_en
      && link_cfg.frames_per_mf == `JLP_RST_FRAMES;
  endproperty
  a_scr_reset: assert property (p_scr_reset)
    else $error("reset values wrong");

  property p_frames_bad;
    wr && acc_idx == `JLP_IDX_FRAMES &&
      !frames_ok(acc_data[`JLP_LOW5]) |=>
      $stable(link_cfg.frames_per_mf);
  endproperty
  a_frames_bad: assert property (p_frames_bad)
    else $error("bad frame count accepted");

  property p_upper_zero;
    wb_ack |-> wb_dat[31:8] == `JLP_PAD;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
endmodule // jlp_link_param_regs

`default_nettype wire

/* File: sim/jlp_tb.sv */
/*
  Self-checking bench for the link parameter bank: a register model
  in the bench is compared with every read and with the link outputs.
  Assumes the hw/ include path and classic Wishbone with byte address
  equal to four times the register index.
*/
`timescale 1ns/1ps
`default_nettype none
`include "jlp_regs.svh"
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); \
    end \
  end

module tb;
  import jlp_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  jlp_wb_req_type wb_req = '0;
  logic wb_ack;
  logic [31:0] wb_dat;
  logic soft_reset_held = 1'b1;
  jlp_id_bytes_type link_id_bytes = '0;
  jlp_link_cfg_type link_cfg;
  logic locked_write_seen;
  logic checksum_match;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 32'hc518;
  logic [31:0] r;
  logic [11:0] i;
  logic [7:0] mreg [16];
  logic m_lws;
  logic [7:0] fr [5] = '{8'h0F, 8'h10, 8'h1F, 8'h00, 8'hEF};

  always #4 sys_clk = ~sys_clk;

  jlp_link_param_regs jlp_link_param_regs_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .wb_req(wb_req),
    .wb_ack(wb_ack),
    .wb_dat(wb_dat),
    .soft_reset_held(soft_reset_held),
    .link_id_bytes(link_id_bytes),
    .link_cfg(link_cfg),
    .locked_write_seen(locked_write_seen),
    .checksum_match(checksum_match)
  );

  // ----------------------------------------
  // Register model
  // ----------------------------------------
  function automatic logic [7:0] msum();
    logic [7:0] s;
    s = link_id_bytes[0] + link_id_bytes[1] + link_id_bytes[2];
    for (int k = 3; k <= 12; k++)
      s = s + mreg[k];
    return s;
  endfunction

  function automatic logic [7:0] mrd(input logic [11:0] a);
    if (a < 12'h453 || a > 12'h45E)
      return 8'h00;
    if (a == 12'h45E)
      return {5'h00, soft_reset_held, m_lws, msum() == mreg[13]};
    return mreg[a[3:0]];
  endfunction

  function automatic jlp_link_cfg_type cfg_exp();
    return '{mreg[3][7], mreg[5][4:0], mreg[8][7:5], mreg[9][7:5],
      mreg[11], mreg[12], mreg[13]};
  endfunction

  task automatic mreset();
    foreach (mreg[k])
      mreg[k] = 8'h00;
    mreg[3] = 8'h87;
    mreg[5] = 8'h1F;
    mreg[6] = 8'h01;
    mreg[7] = 8'h0F;
    mreg[8] = 8'h0F;
    mreg[9] = 8'h01;
    mreg[10] = 8'h80;
    m_lws = 1'b0;
  endtask

  task automatic mwr(input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] s);
    if (!s[0] || a < 12'h453 || a > 12'h45E)
      return;
    if (!soft_reset_held && (a == 12'h458 || a == 12'h459 ||
      (a >= 12'h45B && a <= 12'h45D)))
      m_lws = 1'b1;
    case (a)
      12'h453: mreg[3] = {d[7], 7'h07};
      12'h455: if (d[4:0] == 5'h0F || d[4:0] == 5'h1F)
        mreg[5] = {3'h0, d[4:0]};
      12'h458: mreg[8] = {d[7:5], 5'h0F};
      12'h459: mreg[9] = {d[7:5], 5'h01};
      12'h45B, 12'h45C, 12'h45D: mreg[a[3:0]] = d;
      12'h45E: if (d[1])
        m_lws = 1'b0;
      default: ;
    endcase
  endtask

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [11:0] a,
    input logic [7:0] d, input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {a, 2'b00}, sel: s,
      dat: {24'h00_0000, d}};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack !== 1'b1);
    `CHK(n, 2)
    q = wb_dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
    mwr(a, d, s);
  endtask

  task automatic rd(input logic [11:0] a);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, 4'hF, q);
    `CHK(q, {24'h00_0000, mrd(a)})
  endtask

  task automatic check_all();
    for (int k = 12'h453; k <= 12'h45E; k++)
      rd(k[11:0]);
    @(negedge sys_clk);
    `CHK(link_cfg, cfg_exp())
    `CHK(locked_write_seen, m_lws)
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    r = $random(seed);
    link_id_bytes <= r[23:0];
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    mreset();
    check_all();
    wr(12'h460, 8'hFF, 4'h1);
    rd(12'h460);
    rd(12'h3FF);
    foreach (fr[k])
    begin
      wr(12'h455, fr[k], 4'h1);
      rd(12'h455);
    end
    repeat (40)
    begin
      r = $random(seed);
      i = 12'h453 + {8'h00, r[3:0]};
      if (i == 12'h457)
        r[15:14] = 2'b00;
      if (i == 12'h45A)
        r[12:8] = 5'h00;
      if (i == 12'h458 && r[15:13] == 3'b010)
        r[15:13] = 3'b001;
      wr(i, r[15:8], r[19:16]);
      rd(i);
    end
    @(negedge sys_clk);
    `CHK(link_cfg, cfg_exp())
    // Checksum over the whole parameter range
    wr(12'h45D, msum(), 4'h1);
    @(negedge sys_clk);
    `CHK(checksum_match, 1'b1)
    rd(12'h45E);
    wr(12'h45B, mreg[11] + 8'h01, 4'h1);
    @(negedge sys_clk);
    `CHK(checksum_match, 1'b0)
    // Writes outside soft reset
    @(posedge sys_clk);
    soft_reset_held <= 1'b0;
    wr(12'h455, 8'h0F, 4'h1);
    @(negedge sys_clk);
    `CHK(locked_write_seen, 1'b0)
    wr(12'h458, 8'h20, 4'h1);
    @(negedge sys_clk);
    `CHK(locked_write_seen, 1'b1)
    rd(12'h458);
    rd(12'h45E);
    wr(12'h45E, 8'h02, 4'h1);
    @(negedge sys_clk);
    `CHK(locked_write_seen, 1'b0)
    // Second reset in mid-run
    @(posedge sys_clk);
    reset <= 1'b1;
    soft_reset_held <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    mreset();
    check_all();
    final_report();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end
endmodule // tb
`default_nettype wire
